/* design/gcss_apply.sv */
// Applies gain, offset and deadband corrections to raw measurements
`timescale 1ns/10ps
module gcss_apply (
   input  wire gcss_pkg::gcss_meas_s   meas,
   input  wire logic [15:0]            cur_gain,
   input  wire logic [15:0]            chg_gain,
   input  wire logic signed [15:0]     cnt_ofs,
   input  wire logic signed [15:0]     brd_ofs,
   input  wire logic signed [15:0]     int_tofs,
   input  wire logic signed [15:0]     ext_tofs,
   input  wire logic signed [15:0]     vofs,
   input  wire logic [15:0]            deadband,
   input  wire logic                   ext_temp,
   output gcss_pkg::gcss_rpt_s         rpt
);
   function automatic logic signed [15:0] scale(input logic signed [15:0] v,
                                                input logic [15:0] g);
      logic signed [32:0] p;
      p     = v * $signed({1'b0, g});
      scale = 16'(p >>> gcss_pkg::GAIN_FRAC);
   endfunction

   logic signed [15:0] cur_s;
   logic signed [16:0] dbs;
   always_comb begin
      cur_s = scale(meas.current_ma, cur_gain);
      dbs   = $signed({1'b0, deadband});
      rpt.mean_current_ma = (17'(cur_s) < dbs && 17'(cur_s) > -dbs) ? 16'sh0 : cur_s;
      rpt.charge_scaled   = scale(meas.charge_delta, chg_gain);
      rpt.counter_corr    = meas.counter_raw - cnt_ofs - brd_ofs;
      rpt.temperature     = ext_temp ? meas.temp_ext + ext_tofs
                                     : meas.temp_int + int_tofs;
      rpt.cell_voltage    = meas.volt_raw + vofs;
   end
endmodule // gcss_apply

/* design/gcss_idle_cal.sv */
// Bus-idle timers and the automatic counter offset calibration sequencer
`timescale 1ns/10ps
module gcss_idle_cal #(
   parameter int unsigned IDLE_SHORT = gcss_pkg::IDLE_SHORT_CYC,
   parameter int unsigned IDLE_LONG  = gcss_pkg::IDLE_LONG_CYC,
   parameter int unsigned CAL_RUN    = gcss_pkg::CAL_RUN_CYC
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               bus_low,
   input  wire logic               below_sleep,
   input  wire logic               cal_mode,
   input  wire logic signed [15:0] counter_raw,
   output logic                    running,
   output logic                    done,
   output logic signed [15:0]      result,
   output logic                    long_done
);
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} gcss_acal_e;
   gcss_acal_e         st_q, st_d;
   logic [31:0]        idle_q, idle_d, run_q, run_d;
   logic signed [47:0] acc_q, acc_d;
   logic               long_q, long_d;
   logic               long_cal_q, long_cal_d;

   always_comb begin
      st_d       = st_q;
      idle_d     = bus_low ? ((idle_q == 32'hffffffff) ? idle_q : idle_q + 32'h1) : 32'h0;
      run_d      = run_q;
      acc_d      = acc_q;
      long_d     = long_q;
      long_cal_d = long_cal_q;
      case (st_q)
         S_IDLE: begin
            run_d = 32'h0;
            acc_d = '0;
            if (!cal_mode && bus_low) begin
               if (!long_q && idle_q >= IDLE_LONG) begin
                  st_d       = S_RUN;
                  long_cal_d = 1'b1;
               end else if (idle_q >= IDLE_SHORT && below_sleep) begin
                  st_d       = S_RUN;
                  long_cal_d = 1'b0;
               end
            end
         end
         S_RUN: begin
            run_d = run_q + 32'h1;
            acc_d = acc_q + 48'(counter_raw);
            if (!bus_low) begin
               st_d = S_IDLE;
            end else if (run_q == CAL_RUN - 1) begin
               st_d = S_DONE;
            end
         end
         S_DONE: begin
            if (long_cal_q) begin
               long_d = 1'b1;
            end
            if (!bus_low) begin
               st_d = S_IDLE;
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q       <= S_IDLE;
         idle_q     <= 32'h0;
         run_q      <= 32'h0;
         acc_q      <= '0;
         long_q     <= 1'b0;
         long_cal_q <= 1'b0;
      end else begin
         st_q       <= st_d;
         idle_q     <= idle_d;
         run_q      <= run_d;
         acc_q      <= acc_d;
         long_q     <= long_d;
         long_cal_q <= long_cal_d;
      end
   end

   assign running   = (st_q == S_RUN);
   assign done      = (st_q == S_RUN) && bus_low && (run_q == CAL_RUN - 1);
   // Mean over the run; division by a constant keeps it a single cycle
   // Signed divisor keeps a negative mean from turning into a huge unsigned quotient
   assign result    = 16'(acc_d / $signed(48'(CAL_RUN)));
   assign long_done = long_q;
endmodule // gcss_idle_cal

/* design/gcss_pkg.sv */
// Package: constants, register map, field layouts and carriers of the calibration/security store
package gcss_pkg;
   localparam int unsigned CLK_HZ            = 20000000;
   localparam int unsigned IDLE_SHORT_S      = 5;
   localparam int unsigned CAL_RUN_S         = 16;
   localparam int unsigned IDLE_LONG_S       = 20;
   localparam int unsigned IDLE_SHORT_CYC    = IDLE_SHORT_S * CLK_HZ;
   localparam int unsigned CAL_RUN_CYC       = CAL_RUN_S * CLK_HZ;
   localparam int unsigned IDLE_LONG_CYC     = IDLE_LONG_S * CLK_HZ;
   localparam logic [15:0] DEADBAND_MA_RST   = 16'h0005;
   localparam logic [15:0] SLEEP_MA_RST      = 16'h000a;
   localparam logic [31:0] UNSEAL_CODE_RST   = 32'h36720414;
   localparam logic [31:0] FULL_CODE_RST     = 32'h0fffffff;
   localparam logic [15:0] GAIN_UNITY        = 16'h4000;
   localparam int unsigned GAIN_FRAC         = 14;
   localparam logic [11:0] A_CTRL            = 12'h000;
   localparam logic [11:0] A_STATUS          = 12'h004;
   localparam logic [11:0] A_CUR_GAIN        = 12'h008;
   localparam logic [11:0] A_CHG_GAIN        = 12'h00c;
   localparam logic [11:0] A_CNT_OFS         = 12'h010;
   localparam logic [11:0] A_BRD_OFS         = 12'h014;
   localparam logic [11:0] A_INT_TOFS        = 12'h018;
   localparam logic [11:0] A_EXT_TOFS        = 12'h01c;
   localparam logic [11:0] A_VOFS            = 12'h020;
   localparam logic [11:0] A_DEADBAND        = 12'h024;
   localparam logic [11:0] A_UNSEAL_CODE     = 12'h028;
   localparam logic [11:0] A_FULL_CODE       = 12'h02c;
   localparam logic [11:0] A_KEY             = 12'h030;
   localparam logic [11:0] A_CAL_CMD         = 12'h034;
   localparam logic [11:0] A_CAL_VAL         = 12'h038;
   localparam logic [11:0] A_SLEEP_MA        = 12'h03c;
   // Control register bits
   localparam int unsigned CTRL_CALMODE      = 0;
   localparam int unsigned CTRL_EXT_TEMP     = 1;
   localparam int unsigned CTRL_SEAL         = 2;
   // Calibration command codes written to the command register, then the sense-short length in cycles of a commanded counter offset
   localparam logic [3:0]  CMD_CUR_GAIN      = 4'h1;
   localparam logic [3:0]  CMD_CHG_GAIN      = 4'h2;
   localparam logic [3:0]  CMD_CNT_OFS       = 4'h3;
   localparam logic [3:0]  CMD_INT_TEMP      = 4'h4;
   localparam logic [3:0]  CMD_EXT_TEMP      = 4'h5;
   localparam logic [3:0]  CMD_VOLT          = 4'h6;
   localparam logic [3:0]  CMD_BOARD         = 4'h7;
   localparam logic [2:0]  SHORT_CAL_CYC     = 3'h7;

   typedef enum logic [1:0] {GCSS_SEALED, GCSS_UNSEALED, GCSS_FULL} gcss_mode_e;

   typedef struct packed {
      logic signed [15:0] current_ma;
      logic signed [15:0] charge_delta;
      logic signed [15:0] counter_raw;
      logic signed [15:0] temp_int;
      logic signed [15:0] temp_ext;
      logic signed [15:0] volt_raw;
   } gcss_meas_s;

   typedef struct packed {
      logic signed [15:0] mean_current_ma;
      logic signed [15:0] charge_scaled;
      logic signed [15:0] counter_corr;
      logic signed [15:0] temperature;
      logic signed [15:0] cell_voltage;
   } gcss_rpt_s;
endpackage

/* design/gcss_store.sv */
// Top: calibration constants, access codes and APB register file
// Function
// - Start auto offset calibration after bus low over 5 s and low current.
// - Auto calibration runs about 16 s before replacing counter offset.
// - First bus-low period over 20 s runs the accurate calibration unless a 5 s run started first.
// - Sense inputs are shorted during any counter offset calibration.
// - Mean current inside plus/minus deadband (default 5 mA) reads zero.
// - Mean current scaled by current gain, charge by charge gain.
// - Counter corrected by internal offset and per-board offset.
// - Temperature gets internal or thermistor offset, no gain.
// - Cell voltage gets stored voltage offset from voltage calibration.
// - Unseal code (default 0x36720414) moves unseal_code.
// - Full-access code (default 0xFFFFFFF) moves full_access_code.
`timescale 1ns/10ps
module gcss_store #(
   parameter int unsigned IDLE_SHORT = gcss_pkg::IDLE_SHORT_CYC,
   parameter int unsigned IDLE_LONG  = gcss_pkg::IDLE_LONG_CYC,
   parameter int unsigned CAL_RUN    = gcss_pkg::CAL_RUN_CYC
) (
   input  wire logic                CLK_SYS,
   input  wire logic                RST,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [11:0]         PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic [31:0]              PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic                BUS_CLK_IN,
   input  wire logic                BUS_DATA_IN,
   input  wire gcss_pkg::gcss_meas_s MEAS,
   output gcss_pkg::gcss_rpt_s      RPT,
   output logic                     SENSE_SHORT,
   output logic [1:0]               ACCESS_MODE
);
   // ************************************************************
   // State
   // ************************************************************
   logic [15:0]        cur_gain_q, cur_gain_d, chg_gain_q, chg_gain_d;
   logic signed [15:0] cnt_ofs_q, cnt_ofs_d, brd_ofs_q, brd_ofs_d;
   logic signed [15:0] int_tofs_q, int_tofs_d, ext_tofs_q, ext_tofs_d;
   logic signed [15:0] vofs_q, vofs_d;
   logic [15:0]        deadband_q, deadband_d, sleep_q, sleep_d;
   logic [31:0]        unseal_q, unseal_d, full_q, full_d, cal_val_q, cal_val_d;
   logic               calmode_q, calmode_d, ext_temp_q, ext_temp_d;
   gcss_pkg::gcss_mode_e mode_q, mode_d;
   logic [2:0]         sc_cnt_q, sc_cnt_d;
   logic [31:0]        prdata_q, prdata_d;
   logic               pready_q, pready_d, pslverr_q, pslverr_d;
   logic               short_q, short_d;
   gcss_pkg::gcss_rpt_s rpt_q, rpt_c;

   logic               acal_run, acal_done, long_done;
   logic signed [15:0] acal_res;
   logic               below_sleep;
   logic               bus_low;
   logic               wr, rd;

   assign bus_low = !BUS_CLK_IN && !BUS_DATA_IN;
   assign below_sleep = $signed(rpt_q.mean_current_ma) < $signed({1'b0, sleep_q});
   // PREADY is registered, so reads are looked up one cycle early; writes land
   // only on the edge that samples PREADY high, as the master expects
   assign wr = PSEL && PENABLE && PWRITE && pready_q;
   assign rd = PSEL && PENABLE && !PWRITE && !pready_q;

   // ************************************************************
   // Submodules
   // ************************************************************
   gcss_idle_cal #(
      .IDLE_SHORT (IDLE_SHORT),
      .IDLE_LONG  (IDLE_LONG),
      .CAL_RUN    (CAL_RUN)
   ) u_idle (
      .clk         (CLK_SYS),
      .rst         (RST),
      .bus_low     (bus_low),
      .below_sleep (below_sleep),
      .cal_mode    (calmode_q),
      .counter_raw (MEAS.counter_raw),
      .running     (acal_run),
      .done        (acal_done),
      .result      (acal_res),
      .long_done   (long_done)
   );

   gcss_apply u_apply (
      .meas     (MEAS),
      .cur_gain (cur_gain_q),
      .chg_gain (chg_gain_q),
      .cnt_ofs  (cnt_ofs_q),
      .brd_ofs  (brd_ofs_q),
      .int_tofs (int_tofs_q),
      .ext_tofs (ext_tofs_q),
      .vofs     (vofs_q),
      .deadband (deadband_q),
      .ext_temp (ext_temp_q),
      .rpt      (rpt_c)
   );

   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      case (a)
         gcss_pkg::A_CTRL:        rd_mux = {29'h0, mode_q == gcss_pkg::GCSS_SEALED,
                                            ext_temp_q, calmode_q};
         gcss_pkg::A_STATUS:      rd_mux = {27'h0, long_done, short_q, acal_run, mode_q};
         gcss_pkg::A_CUR_GAIN:    rd_mux = {16'h0, cur_gain_q};
         gcss_pkg::A_CHG_GAIN:    rd_mux = {16'h0, chg_gain_q};
         gcss_pkg::A_CNT_OFS:     rd_mux = {16'h0, cnt_ofs_q};
         gcss_pkg::A_BRD_OFS:     rd_mux = {16'h0, brd_ofs_q};
         gcss_pkg::A_INT_TOFS:    rd_mux = {16'h0, int_tofs_q};
         gcss_pkg::A_EXT_TOFS:    rd_mux = {16'h0, ext_tofs_q};
         gcss_pkg::A_VOFS:        rd_mux = {16'h0, vofs_q};
         gcss_pkg::A_DEADBAND:    rd_mux = {16'h0, deadband_q};
         // Codes are hidden unless full access
         gcss_pkg::A_UNSEAL_CODE: rd_mux = (mode_q == gcss_pkg::GCSS_FULL) ? unseal_q : 32'h0;
         gcss_pkg::A_FULL_CODE:   rd_mux = (mode_q == gcss_pkg::GCSS_FULL) ? full_q : 32'h0;
         gcss_pkg::A_CAL_VAL:     rd_mux = cal_val_q;
         gcss_pkg::A_SLEEP_MA:    rd_mux = {16'h0, sleep_q};
         default:                 rd_mux = 32'h0;
      endcase
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= gcss_pkg::A_SLEEP_MA);
   endfunction

   // ************************************************************
   // Register file, calibration commands and access modes
   // ************************************************************
   always_comb begin
      cur_gain_d = cur_gain_q;
      chg_gain_d = chg_gain_q;
      cnt_ofs_d  = cnt_ofs_q;
      brd_ofs_d  = brd_ofs_q;
      int_tofs_d = int_tofs_q;
      ext_tofs_d = ext_tofs_q;
      vofs_d     = vofs_q;
      deadband_d = deadband_q;
      sleep_d    = sleep_q;
      unseal_d   = unseal_q;
      full_d     = full_q;
      cal_val_d  = cal_val_q;
      calmode_d  = calmode_q;
      ext_temp_d = ext_temp_q;
      mode_d     = mode_q;
      sc_cnt_d   = (sc_cnt_q != 3'h0) ? sc_cnt_q - 3'h1 : 3'h0;
      prdata_d   = prdata_q;
      pready_d   = PSEL && PENABLE && !pready_q;
      pslverr_d  = PSEL && PENABLE && !pready_q && !mapped(PADDR);
      if (acal_done) begin
         cnt_ofs_d = acal_res;
      end
      if (rd) begin
         prdata_d  = rd_mux(PADDR);
      end
      if (wr) begin
         case (PADDR)
            gcss_pkg::A_CTRL: begin
               if (mode_q != gcss_pkg::GCSS_SEALED) begin
                  calmode_d  = PWDATA[gcss_pkg::CTRL_CALMODE];
                  ext_temp_d = PWDATA[gcss_pkg::CTRL_EXT_TEMP];
                  if (PWDATA[gcss_pkg::CTRL_SEAL]) begin
                     mode_d    = gcss_pkg::GCSS_SEALED;
                     calmode_d = 1'b0;
                  end
               end
            end
            gcss_pkg::A_DEADBAND: if (mode_q != gcss_pkg::GCSS_SEALED) deadband_d = PWDATA[15:0];
            gcss_pkg::A_SLEEP_MA: if (mode_q != gcss_pkg::GCSS_SEALED) sleep_d = PWDATA[15:0];
            gcss_pkg::A_UNSEAL_CODE: if (mode_q == gcss_pkg::GCSS_FULL) unseal_d = PWDATA;
            gcss_pkg::A_FULL_CODE:   if (mode_q == gcss_pkg::GCSS_FULL) full_d = PWDATA;
            gcss_pkg::A_CAL_VAL: cal_val_d = PWDATA;
            gcss_pkg::A_KEY: begin
               if (mode_q == gcss_pkg::GCSS_SEALED && PWDATA == unseal_q) begin
                  mode_d = gcss_pkg::GCSS_UNSEALED;
               end else if (mode_q == gcss_pkg::GCSS_UNSEALED && PWDATA == full_q) begin
                  mode_d = gcss_pkg::GCSS_FULL;
               end
            end
            gcss_pkg::A_CAL_CMD: begin
               // Commands move constants only in calibration mode; auto calibration also sets the counter offset
               if (calmode_q) begin
                  case (PWDATA[3:0])
                     gcss_pkg::CMD_CUR_GAIN: cur_gain_d = cal_val_q[15:0];
                     gcss_pkg::CMD_CHG_GAIN: chg_gain_d = cal_val_q[15:0];
                     gcss_pkg::CMD_CNT_OFS: begin
                        cnt_ofs_d = MEAS.counter_raw;
                        sc_cnt_d  = gcss_pkg::SHORT_CAL_CYC;
                     end
                     gcss_pkg::CMD_INT_TEMP: int_tofs_d = cal_val_q[15:0];
                     gcss_pkg::CMD_EXT_TEMP: ext_tofs_d = cal_val_q[15:0];
                     gcss_pkg::CMD_VOLT:     vofs_d = cal_val_q[15:0];
                     gcss_pkg::CMD_BOARD:    brd_ofs_d = cal_val_q[15:0];
                     default: ;
                  endcase
               end
            end
            default: ;
         endcase
      end
      short_d = acal_run || (sc_cnt_d != 3'h0);
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cur_gain_q <= gcss_pkg::GAIN_UNITY;
         chg_gain_q <= gcss_pkg::GAIN_UNITY;
         cnt_ofs_q  <= 16'sh0;
         brd_ofs_q  <= 16'sh0;
         int_tofs_q <= 16'sh0;
         ext_tofs_q <= 16'sh0;
         vofs_q     <= 16'sh0;
         deadband_q <= gcss_pkg::DEADBAND_MA_RST;
         sleep_q    <= gcss_pkg::SLEEP_MA_RST;
         unseal_q   <= gcss_pkg::UNSEAL_CODE_RST;
         full_q     <= gcss_pkg::FULL_CODE_RST;
         cal_val_q  <= 32'h0;
         calmode_q  <= 1'b0;
         ext_temp_q <= 1'b0;
         mode_q     <= gcss_pkg::GCSS_SEALED;
         sc_cnt_q   <= 3'h0;
         prdata_q   <= 32'h0;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
         short_q    <= 1'b0;
         rpt_q      <= '0;
      end else begin
         cur_gain_q <= cur_gain_d;
         chg_gain_q <= chg_gain_d;
         cnt_ofs_q  <= cnt_ofs_d;
         brd_ofs_q  <= brd_ofs_d;
         int_tofs_q <= int_tofs_d;
         ext_tofs_q <= ext_tofs_d;
         vofs_q     <= vofs_d;
         deadband_q <= deadband_d;
         sleep_q    <= sleep_d;
         unseal_q   <= unseal_d;
         full_q     <= full_d;
         cal_val_q  <= cal_val_d;
         calmode_q  <= calmode_d;
         ext_temp_q <= ext_temp_d;
         mode_q     <= mode_d;
         sc_cnt_q   <= sc_cnt_d;
         prdata_q   <= prdata_d;
         pready_q   <= pready_d;
         pslverr_q  <= pslverr_d;
         short_q    <= short_d;
         rpt_q      <= rpt_c;
      end
   end

   assign PRDATA      = prdata_q;
   assign PREADY      = pready_q;
   assign PSLVERR     = pslverr_q;
   assign RPT         = rpt_q;
   assign SENSE_SHORT = short_q;
   assign ACCESS_MODE = mode_q;
endmodule // gcss_store

/* tb/gcss_chk.sv */
// Checker: APB answer timing, offset calibration timing and access-mode steps
`timescale 1ns/10ps
module gcss_chk #(
   parameter int unsigned IDLE_SHORT = 20,
   parameter int unsigned CAL_RUN    = 16
) (
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        BUS_CLK_IN,
   input wire logic        BUS_DATA_IN,
   input wire logic        SENSE_SHORT,
   input wire logic [1:0]  ACCESS_MODE
);
   // ****
   // Helper counters
   // ****
   logic [31:0] idle_q, idle_d, run_q, run_d;
   logic        cmd_q, cmd_d;
   logic        cmd_w;
   // A commanded offset run excuses a short that starts with the bus busy
   assign cmd_w = PREADY && PWRITE && PADDR == gcss_pkg::A_CAL_CMD;
   always_comb begin
      idle_d = (BUS_CLK_IN || BUS_DATA_IN) ? 32'h0 : idle_q + 32'h1;
      run_d  = SENSE_SHORT ? run_q + 32'h1 : 32'h0;
      cmd_d  = (cmd_q && (SENSE_SHORT || run_q == 32'h0))
               || (cmd_w && PWDATA[3:0] == gcss_pkg::CMD_CNT_OFS);
   end
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         idle_q <= 32'h0;
         run_q  <= 32'h0;
         cmd_q  <= 1'b0;
      end else begin
         idle_q <= idle_d;
         run_q  <= run_d;
         cmd_q  <= cmd_d;
      end
   end
   // ****
   // Assertions
   // ****
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("answer not one cycle after access");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_err_addr: assert property (PREADY |-> PSLVERR == (PADDR > 12'h03c || PADDR[1:0] != 2'h0))
      else $error("error flag wrong for address");
   a_short_cause: assert property ($rose(SENSE_SHORT) |-> cmd_q || idle_q >= IDLE_SHORT)
      else $error("offset run started without cause");
   a_short_len: assert property (SENSE_SHORT |-> run_q <= CAL_RUN)
      else $error("offset run too long");
   a_mode_legal: assert property (ACCESS_MODE != 2'h3)
      else $error("illegal access mode");
   a_mode_write: assert property ($changed(ACCESS_MODE) |-> $past(PREADY && PWRITE))
      else $error("mode changed without a write");
   a_mode_step: assert property (ACCESS_MODE > $past(ACCESS_MODE)
      |-> ACCESS_MODE == $past(ACCESS_MODE) + 2'h1)
      else $error("mode skipped a step");
endmodule // gcss_chk

/* tb/gcss_host_model.sv */
// Host model: holds both bus lines high while active, parks them low when idle
`timescale 1ns/10ps
module gcss_host_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic park_low,
   output logic      scl,
   output logic      sda
);
   logic line_q, line_d;
   // Pull-ups hold the lines high whenever the host is awake
   always_comb begin
      line_d = ~park_low;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         line_q <= 1'b1;
      else
         line_q <= line_d;
   end
   assign scl = line_q;
   assign sda = line_q;
endmodule // gcss_host_model

/* tb/tb.sv */
// Testbench: register access, corrections, access codes and automatic offset runs
`timescale 1ns/10ps
module tb;
   localparam int unsigned IS = 20;
   localparam int unsigned IL = 80;
   localparam int unsigned CR = 16;
   logic                 clk = 1'b0, rst = 1'b1, idle_low = 1'b0;
   logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0, prdata, rd;
   logic                 pready, pslverr, sense_short, bus_clk, bus_data, err;
   logic [1:0]           access_mode;
   gcss_pkg::gcss_meas_s meas = '0;
   gcss_pkg::gcss_rpt_s  rpt;
   int                   error_cnt = 0, num_checks = 0, n;
   logic signed [15:0]   dbi[4] = '{16'sd4, -16'sd4, 16'sd5, -16'sd5};
   logic signed [15:0]   dbo[4] = '{16'sd0, 16'sd0, 16'sd5, -16'sd5};
   always #25 clk = ~clk;
   gcss_store #(.IDLE_SHORT(IS), .IDLE_LONG(IL), .CAL_RUN(CR)) gcss_store_inst (
      .CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BUS_CLK_IN(bus_clk), .BUS_DATA_IN(bus_data), .MEAS(meas), .RPT(rpt),
      .SENSE_SHORT(sense_short), .ACCESS_MODE(access_mode));
   gcss_host_model gcss_host_model_inst (.clk(clk), .rst(rst), .park_low(idle_low),
      .scl(bus_clk), .sda(bus_data));
   // ****
   // Tasks
   // ****
   task automatic conclude();
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         error_cnt++;
         conclude();
      end
      @(posedge clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic cal(input logic [3:0] c, input logic [31:0] v);
      apb(1'b1, gcss_pkg::A_CAL_VAL, v);
      apb(1'b1, gcss_pkg::A_CAL_CMD, {28'h0, c});
   endtask
   // Bounded wait; the caller judges the count
   task automatic wait_short(input logic lvl, input int lim);
      n = 0;
      while (sense_short !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(gcss_pkg::A_CUR_GAIN, 32'h4000);
      rdc(gcss_pkg::A_DEADBAND, 32'h5);
      rdc(gcss_pkg::A_UNSEAL_CODE, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, gcss_pkg::A_KEY, 32'h36720415);
      chk({30'h0, access_mode}, 32'h0);
      apb(1'b1, gcss_pkg::A_KEY, 32'h36720414);
      chk({30'h0, access_mode}, 32'h1);
      apb(1'b1, gcss_pkg::A_KEY, 32'h8fffffff);
      chk({30'h0, access_mode}, 32'h1);
      apb(1'b1, gcss_pkg::A_KEY, 32'h0fffffff);
      chk({30'h0, access_mode}, 32'h2);
      rdc(gcss_pkg::A_UNSEAL_CODE, 32'h36720414);
      rdc(gcss_pkg::A_FULL_CODE, 32'h0fffffff);
      apb(1'b1, gcss_pkg::A_CUR_GAIN, 32'h1234);
      rdc(gcss_pkg::A_CUR_GAIN, 32'h4000);
      apb(1'b1, gcss_pkg::A_CTRL, 32'h1);
      foreach (dbi[i]) begin
         meas.current_ma <= dbi[i];
         repeat (2) @(posedge clk);
         chk(rpt.mean_current_ma, dbo[i]);
      end
      cal(gcss_pkg::CMD_CUR_GAIN, 32'h8000);
      cal(gcss_pkg::CMD_CHG_GAIN, 32'h2000);
      meas.current_ma <= 16'sd100;
      meas.charge_delta <= 16'sd100;
      meas.counter_raw <= 16'sd10;
      meas.temp_int <= 16'sd250;
      meas.temp_ext <= 16'sd300;
      meas.volt_raw <= 16'sd3600;
      repeat (2) @(posedge clk);
      chk(rpt.mean_current_ma, 16'sd200);
      chk(rpt.charge_scaled, 16'sd50);
      cal(gcss_pkg::CMD_BOARD, 32'h3);
      cal(gcss_pkg::CMD_CNT_OFS, 32'h0);
      wait_short(1'b1, 4);
      wait_short(1'b0, 20);
      chk(n, 32'h7);
      meas.counter_raw <= 16'sd50;
      repeat (2) @(posedge clk);
      chk(rpt.counter_corr, 16'sd37);
      cal(gcss_pkg::CMD_INT_TEMP, 32'h2);
      cal(gcss_pkg::CMD_EXT_TEMP, 32'hfffc);
      cal(gcss_pkg::CMD_VOLT, 32'h7);
      @(posedge clk);
      chk(rpt.temperature, 16'sd252);
      chk(rpt.cell_voltage, 16'sd3607);
      apb(1'b1, gcss_pkg::A_CTRL, 32'h2);
      @(posedge clk);
      chk(rpt.temperature, 16'sd296);
      // High current: only the first long idle may start a run
      meas.counter_raw <= 16'sd20;
      idle_low <= 1'b1;
      wait_short(1'b1, 60);
      chk(n, 32'd60);
      wait_short(1'b1, 40);
      chk({31'h0, n + 60 >= IL && n + 60 <= IL + 8}, 32'h1);
      wait_short(1'b0, 30);
      chk({31'h0, n >= CR && n <= CR + 1}, 32'h1);
      rdc(gcss_pkg::A_CNT_OFS, 32'h14);
      idle_low <= 1'b0;
      meas.current_ma <= 16'sd0;
      meas.counter_raw <= 16'sd30;
      repeat (4) @(posedge clk);
      idle_low <= 1'b1;
      wait_short(1'b1, 40);
      chk({31'h0, n >= IS && n <= IS + 8}, 32'h1);
      wait_short(1'b0, 30);
      chk({31'h0, n >= CR && n <= CR + 1}, 32'h1);
      rdc(gcss_pkg::A_CNT_OFS, 32'h1e);
      // Sealing again: the full code alone must not leave sealed mode
      apb(1'b1, gcss_pkg::A_CTRL, 32'h4);
      chk({30'h0, access_mode}, 32'h0);
      apb(1'b1, gcss_pkg::A_KEY, 32'h0fffffff);
      chk({30'h0, access_mode}, 32'h0);
      apb(1'b1, gcss_pkg::A_KEY, 32'h36720414);
      chk({30'h0, access_mode}, 32'h1);
      conclude();
   end
endmodule // tb
bind gcss_store gcss_chk #(.IDLE_SHORT(IDLE_SHORT), .CAL_RUN(CAL_RUN)) gcss_chk_inst (
   .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .BUS_CLK_IN(BUS_CLK_IN), .BUS_DATA_IN(BUS_DATA_IN), .SENSE_SHORT(SENSE_SHORT),
   .ACCESS_MODE(ACCESS_MODE));
